// file: srp_params.svh
// Offsets, field positions, reset values and scale constants of the speed reference profile block
`ifndef SRP_PARAMS_SVH
`define SRP_PARAMS_SVH

`define SRP_IDX_CFG5        8'h9C
`define SRP_IDX_CFG6        8'h9E
`define SRP_IDX_DUTYCFG     8'hA0
`define SRP_IDX_STATUS      8'hA2
`define SRP_ADDR_SHIFT      2
`define SRP_RST_CFG5        32'h0000_0000
`define SRP_RST_CFG6        32'h0000_0000
`define SRP_RST_DUTYCFG     32'h0000_0000
`define SRP_WMASK_CFG5      32'hFFFF_FFFE
`define SRP_WMASK_CFG6      32'hFFFF_8000
`define SRP_WMASK_DUTYCFG   32'h0001_FFFF
`define SRP_PARITY_BIT      31
`define SRP_REFB_LSB_BIT    30
`define SRP_REFC_MSB        29
`define SRP_REFC_LSB        22
`define SRP_REFD_MSB        21
`define SRP_REFD_LSB        14
`define SRP_REFE_MSB        13
`define SRP_REFE_LSB        6
`define SRP_MINDUTY_MSB     5
`define SRP_MINDUTY_LSB     4
`define SRP_VMODE_MSB       3
`define SRP_VMODE_LSB       2
`define SRP_FILTER_BIT      1
`define SRP_OFF2_MSB        30
`define SRP_OFF2_LSB        23
`define SRP_CLAMP2_MSB      22
`define SRP_CLAMP2_LSB      15
`define SRP_DUTYC_MSB       7
`define SRP_DUTYC_LSB       0
`define SRP_BAND_MSB        9
`define SRP_BAND_LSB        8
`define SRP_REFBHI_MSB      16
`define SRP_REFBHI_LSB      10
`define SRP_FULL_SCALE      16'd256
`define SRP_PCT_SCALE       16'd100
`define SRP_MIN_PCT0        16'd1
`define SRP_MIN_PCT1        16'd3
`define SRP_MIN_PCT2        16'd5
`define SRP_MIN_PCT3        16'd10
`define SRP_FILT_PERMILLE   16'd4
`define SRP_PERMILLE_SCALE  16'd1000

`endif

// file: srp_pkg.sv
// Types shared by the speed reference profile block
package srp_pkg;
    typedef enum logic [1:0] {
        SRP_REF_MODE  = 2'b01,
        SRP_VOLT_MODE = 2'b10
    } srp_mode_e;

    typedef enum logic [1:0] {
        SRP_VSEL_OFF  = 2'h0,
        SRP_VSEL_HIGH = 2'h1,
        SRP_VSEL_LOW  = 2'h2,
        SRP_VSEL_NA   = 2'h3
    } srp_vsel_e;
endpackage

// file: srp_duty_filter.sv
// Dead-band filter on the measured speed-pin duty
`include "srp_params.svh"
`timescale 1ns/10ps
`default_nettype none
module srp_duty_filter #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] dutyIn,
    output logic      [WIDTH-1:0] dutyOut
);
    // Ten extra bits hold the product by one thousand without wrapping
    localparam int SCALED_W = WIDTH + 10;

    logic [WIDTH-1:0]    held_ff;
    logic [WIDTH-1:0]    nxt_held;
    logic [WIDTH-1:0]    delta;
    logic [SCALED_W-1:0] deltaScaled;
    logic                bigStep;

    // A step counts only when it exceeds the band; small jitter is held off
    assign delta       = (dutyIn > held_ff) ? dutyIn - held_ff : held_ff - dutyIn;
    assign deltaScaled = SCALED_W'(delta) * SCALED_W'(`SRP_PERMILLE_SCALE);
    assign bigStep     = deltaScaled > SCALED_W'(`SRP_FILT_PERMILLE * `SRP_FULL_SCALE);
    assign nxt_held    = (!enable || bigStep) ? dutyIn : held_ff;
    assign dutyOut     = held_ff;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            held_ff <= '0;
        else
            held_ff <= nxt_held;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    pass_when_off_a: assert property (!enable |=> held_ff == $past(dutyIn))
        else $error("Unfiltered duty not passed through");
    hold_small_step_a: assert property (enable && !bigStep |=> $stable(held_ff))
        else $error("Filtered duty moved on a step inside the band");
endmodule
`default_nettype wire

// file: srp_profile_regs.sv
// Speed reference profile configuration registers with AHB-Lite access
//
// Summary of operation
// - Reference B LSB sits at bit 30, joined below seven upper bits.
// - References C, D, E are eight-bit fields at 29-22, 21-14, 13-6.
// - Motor drive starts only once duty reaches 1, 3, 5 or 10 percent.
// - Voltage-mode select 0 keeps reference mode everywhere; code 3 undefined.
// - Select 1: voltage mode above C plus band, reference below C minus band.
// - Select 2: reference mode above C plus band, voltage below C minus band.
// - Bit 1 enables a 0.4 percent speed-pin duty filter, else unfiltered.
// - Second turn-off reference is eight bits at 30-23 of word six.
// - Second clamp reference is eight bits at 22-15 of word six.
// - Duty band width codes 0 to 3 give 0 to 3 percent.
// - Duty point C is its value over 256 of full duty.
//
// The AHB-Lite register port was left to the implementer.
`include "srp_params.svh"
`timescale 1ns/10ps
`default_nettype none
module srp_profile_regs (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic [7:0]  speedDuty,
    output logic      [7:0]  refB,
    output logic      [7:0]  refC,
    output logic      [7:0]  refD,
    output logic      [7:0]  refE,
    output logic      [7:0]  turnoffRefSecond,
    output logic      [7:0]  clampRefSecond,
    output logic             motorEnable,
    output logic             voltageMode
);
    logic [31:0]       cfg5_ff;
    logic [31:0]       cfg6_ff;
    logic [31:0]       dutyCfg_ff;
    logic [31:0]       nxt_cfg5;
    logic [31:0]       nxt_cfg6;
    logic [31:0]       nxt_dutyCfg;
    logic              wrPend_ff;
    logic              rdPend_ff;
    logic [7:0]        index_ff;
    logic [31:0]       rdData_ff;
    logic [31:0]       nxt_rdData;
    logic              motorEnable_ff;
    logic              nxt_motorEnable;
    srp_pkg::srp_mode_e mode_ff;
    srp_pkg::srp_mode_e nxt_mode;

    wire              addrPhase;
    wire [7:0]        addrIndex;
    wire              wrCfg5;
    wire              wrCfg6;
    wire              wrDutyCfg;
    wire [7:0]        filtDuty;
    wire [7:0]        dutyPointC;
    wire [1:0]        bandCode;
    wire [1:0]        minDutyCode;
    wire [1:0]        vselCode;
    wire [15:0]       dutyScaled;
    wire [15:0]       pointScaled;
    wire [15:0]       bandScaled;
    wire              aboveBand;
    wire              belowBand;
    wire              reachedMin;
    wire [31:0]       statusWord;

    // Convert a whole-percent figure into duty counts times one hundred
    function automatic logic [15:0] pct_to_scaled(input logic [15:0] pct);
        pct_to_scaled = 16'(pct * `SRP_FULL_SCALE);
    endfunction

    // Duty counts (over 256 of full scale) times one hundred
    function automatic logic [15:0] duty_to_scaled(input logic [7:0] duty);
        duty_to_scaled = 16'(16'(duty) * `SRP_PCT_SCALE);
    endfunction

    function automatic logic [31:0] masked_write(input logic [31:0] old,
                                                 input logic [31:0] data,
                                                 input logic [31:0] mask);
        masked_write = (old & ~mask) | (data & mask);
    endfunction

    // Bus address phase; every access completes with no wait state
    assign addrPhase = hsel && htrans[1] && hready;
    assign addrIndex = haddr[`SRP_ADDR_SHIFT +: 8];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdData_ff;

    assign wrCfg5    = wrPend_ff && index_ff == `SRP_IDX_CFG5;
    assign wrCfg6    = wrPend_ff && index_ff == `SRP_IDX_CFG6;
    assign wrDutyCfg = wrPend_ff && index_ff == `SRP_IDX_DUTYCFG;

    // Reserved bits stay zero because the masks never open them
    assign nxt_cfg5    = wrCfg5 ? masked_write(cfg5_ff, hwdata, `SRP_WMASK_CFG5) : cfg5_ff;
    assign nxt_cfg6    = wrCfg6 ? masked_write(cfg6_ff, hwdata, `SRP_WMASK_CFG6) : cfg6_ff;
    assign nxt_dutyCfg = wrDutyCfg ? masked_write(dutyCfg_ff, hwdata, `SRP_WMASK_DUTYCFG)
                                   : dutyCfg_ff;

    assign statusWord = {16'h0000, filtDuty, 6'h00, motorEnable_ff,
                         mode_ff == srp_pkg::SRP_VOLT_MODE};

    // Read data is taken from next-state values so a write followed at once
    // by a read of the same word returns the new contents
    assign nxt_rdData = !(addrPhase && !hwrite)              ? 32'h0000_0000 :
                        addrIndex == `SRP_IDX_CFG5    ? nxt_cfg5    :
                        addrIndex == `SRP_IDX_CFG6    ? nxt_cfg6    :
                        addrIndex == `SRP_IDX_DUTYCFG ? nxt_dutyCfg :
                        addrIndex == `SRP_IDX_STATUS  ? statusWord  : 32'h0000_0000;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wrPend_ff <= 1'b0;
            rdPend_ff <= 1'b0;
            index_ff  <= 8'h00;
            rdData_ff <= 32'h0000_0000;
        end
        else
        begin
            wrPend_ff <= addrPhase && hwrite;
            rdPend_ff <= addrPhase && !hwrite;
            index_ff  <= addrPhase ? addrIndex : index_ff;
            rdData_ff <= nxt_rdData;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cfg5_ff    <= `SRP_RST_CFG5;
            cfg6_ff    <= `SRP_RST_CFG6;
            dutyCfg_ff <= `SRP_RST_DUTYCFG;
        end
        else
        begin
            cfg5_ff    <= nxt_cfg5;
            cfg6_ff    <= nxt_cfg6;
            dutyCfg_ff <= nxt_dutyCfg;
        end
    end

    // Reference outputs straight from the configuration flops
    assign refB = {dutyCfg_ff[`SRP_REFBHI_MSB:`SRP_REFBHI_LSB],
                   cfg5_ff[`SRP_REFB_LSB_BIT]};
    assign refC = cfg5_ff[`SRP_REFC_MSB:`SRP_REFC_LSB];
    assign refD = cfg5_ff[`SRP_REFD_MSB:`SRP_REFD_LSB];
    assign refE = cfg5_ff[`SRP_REFE_MSB:`SRP_REFE_LSB];
    assign turnoffRefSecond = cfg6_ff[`SRP_OFF2_MSB:`SRP_OFF2_LSB];
    assign clampRefSecond   = cfg6_ff[`SRP_CLAMP2_MSB:`SRP_CLAMP2_LSB];

    srp_duty_filter #(
        .WIDTH (8)
    ) u_filter (
        .clock   (clock),
        .reset   (reset),
        .enable  (cfg5_ff[`SRP_FILTER_BIT]),
        .dutyIn  (speedDuty),
        .dutyOut (filtDuty)
    );

    assign dutyPointC  = dutyCfg_ff[`SRP_DUTYC_MSB:`SRP_DUTYC_LSB];
    assign bandCode    = dutyCfg_ff[`SRP_BAND_MSB:`SRP_BAND_LSB];
    assign minDutyCode = cfg5_ff[`SRP_MINDUTY_MSB:`SRP_MINDUTY_LSB];
    assign vselCode    = cfg5_ff[`SRP_VMODE_MSB:`SRP_VMODE_LSB];

    // All comparisons run in duty counts times one hundred to keep
    // whole-percent thresholds exact without a divider
    assign dutyScaled  = duty_to_scaled(filtDuty);
    assign pointScaled = duty_to_scaled(dutyPointC);
    assign bandScaled  = pct_to_scaled(16'(bandCode));
    assign aboveBand   = 17'(dutyScaled) > 17'(pointScaled) + 17'(bandScaled);
    assign belowBand   = 17'(dutyScaled) + 17'(bandScaled) < 17'(pointScaled);

    assign reachedMin = dutyScaled >= pct_to_scaled(
        minDutyCode == 2'h0 ? `SRP_MIN_PCT0 :
        minDutyCode == 2'h1 ? `SRP_MIN_PCT1 :
        minDutyCode == 2'h2 ? `SRP_MIN_PCT2 : `SRP_MIN_PCT3);
    assign nxt_motorEnable = reachedMin;

    // Code 3 is undefined; it is treated as code 0 so the mode stays safe
    always_comb
    begin
        nxt_mode = mode_ff;
        unique case (srp_pkg::srp_vsel_e'(vselCode))
            srp_pkg::SRP_VSEL_HIGH:
            begin
                if (aboveBand)
                    nxt_mode = srp_pkg::SRP_VOLT_MODE;
                else if (belowBand)
                    nxt_mode = srp_pkg::SRP_REF_MODE;
            end
            srp_pkg::SRP_VSEL_LOW:
            begin
                if (aboveBand)
                    nxt_mode = srp_pkg::SRP_REF_MODE;
                else if (belowBand)
                    nxt_mode = srp_pkg::SRP_VOLT_MODE;
            end
            srp_pkg::SRP_VSEL_OFF,
            srp_pkg::SRP_VSEL_NA:
                nxt_mode = srp_pkg::SRP_REF_MODE;
        endcase
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            mode_ff        <= srp_pkg::SRP_REF_MODE;
            motorEnable_ff <= 1'b0;
        end
        else
        begin
            mode_ff        <= nxt_mode;
            motorEnable_ff <= nxt_motorEnable;
        end
    end

    assign motorEnable = motorEnable_ff;
    assign voltageMode = mode_ff == srp_pkg::SRP_VOLT_MODE;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    refb_join_a: assert property (refB[0] == cfg5_ff[30] && refB[7:1] == dutyCfg_ff[16:10])
        else $error("Reference B not joined from its two parts");
    refc_write_a: assert property (wrCfg5 |=> refC == $past(hwdata[29:22]))
        else $error("Reference C did not follow a write");
    min_duty_a: assert property (minDutyCode == 2'h3 && filtDuty < 8'd25 |=> !motorEnable)
        else $error("Motor enabled below ten percent duty");
    off_mode_a: assert property (vselCode == 2'h0 |=> !voltageMode)
        else $error("Voltage mode chosen while select is zero");
    high_sel_a: assert property (vselCode == 2'h1 && aboveBand |=> voltageMode)
        else $error("Voltage mode not entered above the band");
    low_sel_a: assert property (vselCode == 2'h2 && belowBand |=> voltageMode)
        else $error("Voltage mode not entered below the band");
    off2_write_a: assert property (wrCfg6 |=> turnoffRefSecond == $past(hwdata[30:23]))
        else $error("Second turn-off reference did not follow a write");
    clamp2_write_a: assert property (wrCfg6 |=> clampRefSecond == $past(hwdata[22:15]))
        else $error("Second clamp reference did not follow a write");
    band_hold_a: assert property (vselCode != 2'h0 && vselCode != 2'h3 && !aboveBand
                                  && !belowBand |=> $stable(mode_ff))
        else $error("Mode changed inside the band");
    band_zero_a: assert property (bandCode == 2'h0 && vselCode == 2'h1
                                  && filtDuty > dutyPointC |=> voltageMode)
        else $error("Zero band width not honoured");
    read_data_a: assert property (rdPend_ff && index_ff == `SRP_IDX_CFG6 |->
                                  hrdata[14:0] == 15'h0000)
        else $error("Reserved bits of word six read nonzero");

    // Second forms on the raw field values, so a slip in the shared scaling shows up
    refb_lsb_write_a: assert property (wrCfg5 |=> refB[0] == $past(hwdata[30]))
        else $error("Reference B low bit did not follow a write");
    refb_high_write_a: assert property (wrDutyCfg |=> refB[7:1] == $past(hwdata[16:10]))
        else $error("Reference B upper bits did not follow a write");
    refd_write_a: assert property (wrCfg5 |=> refD == $past(hwdata[21:14]))
        else $error("Reference D did not follow a write");
    refe_write_a: assert property (wrCfg5 |=> refE == $past(hwdata[13:6]))
        else $error("Reference E did not follow a write");
    refs_hold_a: assert property (!wrCfg5 |=> $stable(refC) && $stable(refD)
        && $stable(refE))
        else $error("Word five references moved without a write");
    refs6_hold_a: assert property (!wrCfg6 |=> $stable(turnoffRefSecond)
        && $stable(clampRefSecond))
        else $error("Word six references moved without a write");
    min_on0_a: assert property (minDutyCode == 2'h0 && filtDuty >= 8'd3 |=> motorEnable)
        else $error("Motor not enabled at one percent duty");
    min_off0_a: assert property (minDutyCode == 2'h0 && filtDuty < 8'd3 |=> !motorEnable)
        else $error("Motor enabled below one percent duty");
    min_on1_a: assert property (minDutyCode == 2'h1 && filtDuty >= 8'd8 |=> motorEnable)
        else $error("Motor not enabled at three percent duty");
    min_off1_a: assert property (minDutyCode == 2'h1 && filtDuty < 8'd8 |=> !motorEnable)
        else $error("Motor enabled below three percent duty");
    min_on2_a: assert property (minDutyCode == 2'h2 && filtDuty >= 8'd13 |=> motorEnable)
        else $error("Motor not enabled at five percent duty");
    min_off2_a: assert property (minDutyCode == 2'h2 && filtDuty < 8'd13 |=> !motorEnable)
        else $error("Motor enabled below five percent duty");
    min_on3_a: assert property (minDutyCode == 2'h3 && filtDuty >= 8'd26 |=> motorEnable)
        else $error("Motor not enabled at ten percent duty");
    min_off3_a: assert property (minDutyCode == 2'h3 && filtDuty < 8'd26 |=> !motorEnable)
        else $error("Motor enabled just below ten percent duty");
    sel_three_a: assert property (vselCode == 2'h3 |=> !voltageMode)
        else $error("Voltage mode chosen while select is undefined");
    high_below_a: assert property (vselCode == 2'h1 && belowBand |=> !voltageMode)
        else $error("Reference mode not taken below the band");
    low_above_a: assert property (vselCode == 2'h2 && aboveBand |=> !voltageMode)
        else $error("Reference mode not taken above the band");
    band_two_up_a: assert property (bandCode == 2'h2 && vselCode == 2'h1
        && 16'(filtDuty) * 16'd100 > 16'(dutyPointC) * 16'd100 + 16'd512 |=> voltageMode)
        else $error("Two percent band not honoured above point C");
    band_two_down_a: assert property (bandCode == 2'h2 && vselCode == 2'h1
        && 16'(filtDuty) * 16'd100 + 16'd512 < 16'(dutyPointC) * 16'd100 |=> !voltageMode)
        else $error("Two percent band not honoured below point C");
    point_c_below_a: assert property (bandCode == 2'h0 && vselCode == 2'h1
        && filtDuty < dutyPointC |=> !voltageMode)
        else $error("Point C not used as the switching threshold");
    pointc_write_a: assert property (wrDutyCfg |=> dutyPointC == $past(hwdata[7:0]))
        else $error("Duty point C did not follow a write");
    band_write_a: assert property (wrDutyCfg |=> bandCode == $past(hwdata[9:8]))
        else $error("Band width code did not follow a write");
    filter_link_a: assert property (!cfg5_ff[1] |=> filtDuty == $past(speedDuty))
        else $error("Speed duty not passed through with the filter off");
    mode_legal_a: assert property (mode_ff == srp_pkg::SRP_REF_MODE
        || mode_ff == srp_pkg::SRP_VOLT_MODE)
        else $error("Mode register holds an illegal code");

    // Bus side: no wait states, and read data only in its own data phase
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("Bus answered with a wait state or an error");
    idle_rdata_a: assert property (!rdPend_ff |-> hrdata == 32'h0000_0000)
        else $error("Read data shown outside a read data phase");
    wr_capture_a: assert property (addrPhase && hwrite
        |=> wrPend_ff && index_ff == $past(addrIndex))
        else $error("Write address phase not captured");
    wr_unmapped_a: assert property (wrPend_ff && !wrCfg5 && !wrCfg6 && !wrDutyCfg
        |=> $stable(cfg5_ff) && $stable(cfg6_ff) && $stable(dutyCfg_ff))
        else $error("Write to an unmapped or read-only word changed a register");
    rd_cfg5_a: assert property (addrPhase && !hwrite && addrIndex == `SRP_IDX_CFG5
        && !wrPend_ff |=> hrdata == $past(cfg5_ff))
        else $error("Word five read back differs from its contents");
    rd_cfg6_a: assert property (addrPhase && !hwrite && addrIndex == `SRP_IDX_CFG6
        && !wrPend_ff |=> hrdata == $past(cfg6_ff))
        else $error("Word six read back differs from its contents");
    rd_dutycfg_a: assert property (addrPhase && !hwrite && addrIndex == `SRP_IDX_DUTYCFG
        && !wrPend_ff |=> hrdata == $past(dutyCfg_ff))
        else $error("Duty word read back differs from its contents");
    status_read_a: assert property (addrPhase && !hwrite && addrIndex == `SRP_IDX_STATUS
        |=> hrdata[15:8] == $past(filtDuty) && hrdata[1] == $past(motorEnable)
        && hrdata[0] == $past(voltageMode))
        else $error("Status word does not show the filtered duty and the mode");
    rsvd_bits_a: assert property (cfg5_ff[0] == 1'b0 && cfg6_ff[14:0] == 15'h0000
        && dutyCfg_ff[31:17] == 15'h0000)
        else $error("A reserved register bit is set");
endmodule
`default_nettype wire

// file: test_srp_profile_regs.sv
// Self-checking testbench of the speed reference profile register block
`include "srp_params.svh"
`timescale 1ns/10ps
`default_nettype none
module test_srp_profile_regs;
    localparam logic [31:0] ADDR5 = {22'h0, `SRP_IDX_CFG5, 2'h0};
    localparam logic [31:0] ADDR6 = {22'h0, `SRP_IDX_CFG6, 2'h0};
    localparam logic [31:0] ADDRD = {22'h0, `SRP_IDX_DUTYCFG, 2'h0};
    localparam logic [31:0] ADDRS = {22'h0, `SRP_IDX_STATUS, 2'h0};
    localparam logic [31:0] ADDRX = {22'h0, 8'h9D, 2'h0};
    logic        clock, reset, hsel, hwrite, hreadyout, hresp, motorEnable, voltageMode;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rdSampled, rd;
    logic [7:0]  speedDuty, refB, refC, refD, refE, turnoffRefSecond, clampRefSecond;
    int          num_errors, cmp_count, cycles;

    srp_profile_regs dut_u (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .speedDuty(speedDuty),
        .refB(refB), .refC(refC), .refD(refD), .refE(refE),
        .turnoffRefSecond(turnoffRefSecond), .clampRefSecond(clampRefSecond),
        .motorEnable(motorEnable), .voltageMode(voltageMode));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Read data is captured at the edge itself so the task never races the slave
    always @(posedge clock) rdSampled <= hrdata;

    // Whole run needs well under two thousand cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (exp !== got)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic [31:0] addr, input logic wr, input logic [31:0] wdata);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        #1;
        rd = rdSampled;
    endtask

    // Duty reaches the mode outputs two edges after it is applied
    task automatic set_duty(input logic [7:0] d);
        @(posedge clock);
        speedDuty <= d;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic test_reset_values();
        bus(ADDR5, 1'b0, 32'h0);
        check("cfg5 reset", `SRP_RST_CFG5, rd);
        bus(ADDR6, 1'b0, 32'h0);
        check("cfg6 reset", `SRP_RST_CFG6, rd);
        check("hresp", 32'h0, {31'h0, hresp});
        check("refs after reset", 32'h0, {refB, refC, refD, refE});
        check("outputs after reset", 32'h1, {turnoffRefSecond, clampRefSecond, 13'h0,
                                             motorEnable, voltageMode, hreadyout});
    endtask

    task automatic test_ref_fields();
        bus(ADDR5, 1'b1, {1'b1, 1'b1, 8'hA5, 8'h3C, 8'hC3, 2'h2, 2'h1, 1'b0, 1'b1});
        bus(ADDRD, 1'b1, {15'h0, 7'h55, 2'h0, 8'h00});
        bus(ADDR5, 1'b0, 32'h0);
        check("cfg5 readback", {1'b1, 1'b1, 8'hA5, 8'h3C, 8'hC3, 2'h2, 2'h1, 2'h0}, rd);
        check("refB", 32'hAB, {24'h0, refB});
        check("refC", 32'hA5, {24'h0, refC});
        check("refD", 32'h3C, {24'h0, refD});
        check("refE", 32'hC3, {24'h0, refE});
        bus(ADDRD, 1'b0, 32'h0);
        check("dutycfg readback", {15'h0, 7'h55, 2'h0, 8'h00}, rd);
        bus(ADDR6, 1'b1, {1'b1, 8'h5A, 8'h96, 15'h7FFF});
        bus(ADDR6, 1'b0, 32'h0);
        check("cfg6 readback", {1'b1, 8'h5A, 8'h96, 15'h0}, rd);
        check("turnoffRefSecond", 32'h5A, {24'h0, turnoffRefSecond});
        check("clampRefSecond", 32'h96, {24'h0, clampRefSecond});
        bus(ADDRX, 1'b1, 32'hFFFF_FFFF);
        bus(ADDRX, 1'b0, 32'h0);
        check("unmapped read", 32'h0, rd);
    endtask

    task automatic test_min_duty();
        int pct[4] = '{1, 3, 5, 10};
        int thr;
        for (int c = 0; c < 4; c++)
        begin
            bus(ADDR5, 1'b1, {26'h0, c[1:0], 4'h0});
            thr = (pct[c] * 256 + 99) / 100;
            set_duty(8'(thr - 1));
            check("motorEnable below", 32'h0, {31'h0, motorEnable});
            set_duty(8'(thr));
            check("motorEnable at", 32'h1, {31'h0, motorEnable});
        end
    endtask

    // Point C at 128 and band code 2: above from 134, below from 122, kept between
    task automatic test_mode_select();
        int du[6] = '{100, 133, 134, 128, 123, 122};
        bit hi[6] = '{0, 0, 1, 1, 1, 0};
        logic exp;
        bus(ADDRD, 1'b1, {15'h0, 7'h00, 2'h2, 8'h80});
        for (int v = 0; v < 4; v++)
        begin
            bus(ADDR5, 1'b1, {28'h0, v[1:0], 2'h0});
            for (int i = 0; i < 6; i++)
            begin
                set_duty(8'(du[i]));
                exp = (v == 1) ? hi[i] : (v == 2) ? !hi[i] : 1'b0;
                check("voltageMode", {31'h0, exp}, {31'h0, voltageMode});
            end
        end
        bus(ADDRD, 1'b1, {15'h0, 7'h00, 2'h0, 8'h80});
        bus(ADDR5, 1'b1, {28'h0, 2'h1, 2'h0});
        set_duty(8'd129);
        check("voltageMode band 0 above", 32'h1, {31'h0, voltageMode});
        set_duty(8'd128);
        check("voltageMode band 0 at C", 32'h1, {31'h0, voltageMode});
        set_duty(8'd127);
        check("voltageMode band 0 below", 32'h0, {31'h0, voltageMode});
    endtask

    task automatic test_filter();
        bus(ADDR5, 1'b1, 32'h0000_0002);
        set_duty(8'd50);
        bus(ADDRS, 1'b0, 32'h0);
        check("filtered duty 50", 32'd50, {24'h0, rd[15:8]});
        set_duty(8'd51);
        bus(ADDRS, 1'b0, 32'h0);
        check("filtered duty held", 32'd50, {24'h0, rd[15:8]});
        set_duty(8'd52);
        bus(ADDRS, 1'b0, 32'h0);
        check("filtered duty 52", 32'd52, {24'h0, rd[15:8]});
        set_duty(8'd118);
        bus(ADDRS, 1'b0, 32'h0);
        check("filtered duty large step", 32'd118, {24'h0, rd[15:8]});
        bus(ADDR5, 1'b1, 32'h0);
        set_duty(8'd53);
        bus(ADDRS, 1'b0, 32'h0);
        check("unfiltered duty", 32'd53, {24'h0, rd[15:8]});
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        reset = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        speedDuty = 8'h00;
        num_errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        test_reset_values();
        test_ref_fields();
        test_min_duty();
        test_mode_select();
        test_filter();
        give_verdict();
    end
endmodule
`default_nettype wire
